// *** src/arc_defines.vh ***
// Constants for the alarm report and clear block
`ifndef ARC_DEFINES_VH
`define ARC_DEFINES_VH
// ---------------------------------------------------------------
// Object index and codes
// ---------------------------------------------------------------
`define ARC_ACTIVE_ERROR_CODE_IDX 16'h603F
`define ARC_ERR_CODE_RESET        16'h0000
`define ARC_MFR_UPPER             8'hFF
`define ARC_ALARM_MAX             8'h9F
`define ARC_WARN_LO               8'hA0
`define ARC_WARN_HI               8'hA9
`define ARC_WARN_C3               8'hC3
`define ARC_WARN_D2               8'hD2
`define ARC_WARN_D3               8'hD3
// ---------------------------------------------------------------
// Bit positions
// ---------------------------------------------------------------
`define ARC_AL_CTRL_ACK_BIT       4
`define ARC_CTRL_WORD_RESET_BIT   7
// ---------------------------------------------------------------
// Drive state machine codes (one-hot)
// ---------------------------------------------------------------
`define ARC_DSM_W                 4
`define ARC_DSM_SWITCH_ON_DIS     4'h1
`define ARC_DSM_OPERATING         4'h2
`define ARC_DSM_FAULT_REACT       4'h4
`define ARC_DSM_FAULT             4'h8
`endif

// *** src/arc_rise_detect.v ***
// Two-flop synchroniser with rising edge detect
`timescale 1ns/10ps
module arc_rise_detect
(
   // Clock and reset
   input  wire clk,
   input  wire rst,
   // Asynchronous level in
   input  wire asyncIn,
   // Synchronised level and rising edge
   output wire levelOut,
   output wire riseOut
);
   reg meta_q;
   reg sync_q;
   reg last_q;

   always @(posedge clk)
   begin
      if (rst)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end
      else
      begin
         meta_q <= asyncIn;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign levelOut = sync_q;
   assign riseOut  = sync_q & ~last_q;
endmodule

// *** src/arc_code_encode.v ***
// Encodes active alarm or warning into the error code object
`timescale 1ns/10ps
`include "arc_defines.vh"
module arc_code_encode
(
   // Condition inputs
   input  wire       alarmValid,
   input  wire [7:0] alarmMain,
   input  wire       warnValid,
   input  wire [7:0] warnNum,
   // Encoded code
   output reg  [15:0] codeOut
);
   wire alarmOk;
   wire warnOk;

   assign alarmOk = alarmValid && (alarmMain <= `ARC_ALARM_MAX);
   assign warnOk  = warnValid &&
                    (((warnNum >= `ARC_WARN_LO) &&
                      (warnNum <= `ARC_WARN_HI)) ||
                     (warnNum == `ARC_WARN_C3) ||
                     (warnNum == `ARC_WARN_D2) ||
                     (warnNum == `ARC_WARN_D3));

   always @*
   begin
      if (alarmOk)
         codeOut = {`ARC_MFR_UPPER, alarmMain};
      else if (warnOk)
         codeOut = {`ARC_MFR_UPPER, warnNum};
      else
         codeOut = `ARC_ERR_CODE_RESET;
   end
endmodule

// *** src/arc_alarm_clear.v ***
// Alarm and warning reporting and clearing core
`timescale 1ns/10ps
`include "arc_defines.vh"
// Functional notes
// - Code zero with no alarm or warning
// - Alarm wins over warning in code
// - Upper byte FF, main number low
// - Alarms 00-9F; warnings A0-A9,C3,D2,D3
// - Sub alarm number never exposed
// - Ack bit then control bit7 rise clears
// - Clear moves Fault to Switch on disabled
// - Clear input OFF-to-ON edge clears
// - Setup tool clear request also clears
// - Clear input ON blocks bus/tool clear
// - Fault reaction active ignores all clears
// - Clear refused while any cause remains
// - First error held on display
// - Comm error updates indicators, latest wins
// - Latched warning clears by clears or by a new warning with latch off
// - No warning while clear input ON
// - Status notice may lag the event
module arc_alarm_clear
#(
   parameter NOTICE_DELAY = 4
)
(
   // Clock and reset
   input  wire        clk,
   input  wire        rst,
   // Fieldbus master control
   input  wire [7:0]  alControl,
   input  wire [15:0] controlWord,
   // Setup tool clear request, one-cycle pulse
   input  wire        toolClearReq,
   // External alarm clear pin
   input  wire        ext_alarm_clear_input,
   // Alarm causes
   input  wire        alarmEvent,
   input  wire [7:0]  alarmMain,
   input  wire        alarmCauseActive,
   input  wire        alarmClearable,
   // Warning causes
   input  wire        warnCause,
   input  wire [7:0]  warnNum,
   input  wire        warnLatchEn,
   // Drive state requests
   input  wire        faultReactDone,
   input  wire        enableOperation,
   // Communication error reports
   input  wire        commErrEvent,
   input  wire        commRunLed,
   input  wire        commErrLed,
   input  wire [3:0]  commBusState,
   input  wire [15:0] commAlStatus,
   // Object and status outputs
   output reg  [15:0] active_error_code,
   output reg  [3:0]  drive_state_machine,
   output reg  [7:0]  segDisplay,
   output reg         runLed,
   output reg         errLed,
   output reg  [3:0]  busState,
   output reg  [15:0] alStatus,
   output reg         alNotice,
   output wire        clearDone
);
   // ------------------------------------------------------------
   // Input synchronisation
   // ------------------------------------------------------------
   wire extLevel;
   wire extRise;

   arc_rise_detect uExt
   (
      .clk      (clk),
      .rst      (rst),
      .asyncIn  (ext_alarm_clear_input),
      .levelOut (extLevel),
      .riseOut  (extRise)
   );

   // ------------------------------------------------------------
   // Fault reset edge detect
   // ------------------------------------------------------------
   reg resetBitLast_q;
   reg ackSeen_q;
   wire resetRise;

   assign resetRise = controlWord[`ARC_CTRL_WORD_RESET_BIT] &
                      ~resetBitLast_q;

   always @(posedge clk)
   begin
      if (rst)
      begin
         resetBitLast_q <= 1'b0;
         ackSeen_q      <= 1'b0;
      end
      else
      begin
         resetBitLast_q <= controlWord[`ARC_CTRL_WORD_RESET_BIT];
         if (alControl[`ARC_AL_CTRL_ACK_BIT])
            ackSeen_q <= 1'b1;
         else if (resetRise)
            ackSeen_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Clear decision
   // ------------------------------------------------------------
   wire inReact;
   wire busClear;
   wire toolClear;
   wire anyClear;
   wire warnClear;
   reg  alarm_q;

   assign inReact   = drive_state_machine == `ARC_DSM_FAULT_REACT;
   assign busClear  = resetRise &&
                      (ackSeen_q ||
                       alControl[`ARC_AL_CTRL_ACK_BIT]) &&
                      !extLevel;
   assign toolClear = toolClearReq && !extLevel;
   assign anyClear  = (busClear || toolClear || extRise) &&
                      !inReact;
   assign warnClear = (resetRise || toolClear || extRise) &&
                      !inReact;
   assign clearDone = anyClear && alarm_q && !alarmCauseActive &&
                      alarmClearable;

   // ------------------------------------------------------------
   // Alarm and warning state
   // ------------------------------------------------------------
   reg [7:0] alarmNum_q;
   reg       warnLatch_q;
   reg [7:0] warnNum_q;
   wire      warnNow;

   assign warnNow = warnCause && !extLevel;

   always @(posedge clk)
   begin
      if (rst)
      begin
         alarm_q     <= 1'b0;
         alarmNum_q  <= 8'h00;
         warnLatch_q <= 1'b0;
         warnNum_q   <= 8'h00;
      end
      else
      begin
         if (alarmEvent && !alarm_q)
         begin
            alarm_q    <= 1'b1;
            alarmNum_q <= alarmMain;
         end
         else if (clearDone)
            alarm_q <= 1'b0;
         if (warnNow)
         begin
            warnLatch_q <= warnLatchEn;
            warnNum_q   <= warnNum;
         end
         else if (warnClear)
            warnLatch_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Error code object
   // ------------------------------------------------------------
   wire [15:0] codeNext;

   arc_code_encode uEnc
   (
      .alarmValid (alarm_q),
      .alarmMain  (alarmNum_q),
      .warnValid  (warnNow || warnLatch_q),
      .warnNum    (warnNow ? warnNum : warnNum_q),
      .codeOut    (codeNext)
   );

   always @(posedge clk)
   begin
      if (rst)
         active_error_code <= `ARC_ERR_CODE_RESET;
      else
         active_error_code <= codeNext;
   end

   // ------------------------------------------------------------
   // Drive state machine
   // ------------------------------------------------------------
   always @(posedge clk)
   begin
      if (rst)
         drive_state_machine <= `ARC_DSM_SWITCH_ON_DIS;
      else
      begin
         case (drive_state_machine)
            `ARC_DSM_SWITCH_ON_DIS:
            begin
               if (alarmEvent)
                  drive_state_machine <= `ARC_DSM_FAULT_REACT;
               else if (enableOperation)
                  drive_state_machine <= `ARC_DSM_OPERATING;
            end
            `ARC_DSM_OPERATING:
            begin
               if (alarmEvent)
                  drive_state_machine <= `ARC_DSM_FAULT_REACT;
               else if (!enableOperation)
                  drive_state_machine <= `ARC_DSM_SWITCH_ON_DIS;
            end
            `ARC_DSM_FAULT_REACT:
            begin
               if (faultReactDone)
                  drive_state_machine <= `ARC_DSM_FAULT;
            end
            `ARC_DSM_FAULT:
            begin
               if (clearDone)
                  drive_state_machine <= `ARC_DSM_SWITCH_ON_DIS;
            end
            default:
               drive_state_machine <= `ARC_DSM_SWITCH_ON_DIS;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Segment display
   // ------------------------------------------------------------
   reg dispHeld_q;

   always @(posedge clk)
   begin
      if (rst)
      begin
         dispHeld_q <= 1'b0;
         segDisplay <= 8'h00;
      end
      else if (alarmEvent && !dispHeld_q)
      begin
         dispHeld_q <= 1'b1;
         segDisplay <= alarmMain;
      end
      else if (clearDone)
      begin
         dispHeld_q <= 1'b0;
         segDisplay <= 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Communication error indicators
   // ------------------------------------------------------------
   always @(posedge clk)
   begin
      if (rst)
      begin
         runLed   <= 1'b0;
         errLed   <= 1'b0;
         busState <= 4'h0;
         alStatus <= 16'h0000;
      end
      else if (commErrEvent)
      begin
         runLed   <= commRunLed;
         errLed   <= commErrLed;
         busState <= commBusState;
         alStatus <= commAlStatus;
      end
   end

   // ------------------------------------------------------------
   // Delayed status notice
   // ------------------------------------------------------------
   reg [NOTICE_DELAY-1:0] noticePipe_q;

   always @(posedge clk)
   begin
      if (rst)
      begin
         noticePipe_q <= {NOTICE_DELAY{1'b0}};
         alNotice     <= 1'b0;
      end
      else
      begin
         noticePipe_q <= {noticePipe_q[NOTICE_DELAY-2:0],
                          (codeNext != `ARC_ERR_CODE_RESET)};
         alNotice     <= noticePipe_q[NOTICE_DELAY-1];
      end
   end
endmodule

// *** bench/arc_props.sv ***
// Checker for the alarm report and clear block
`timescale 1ns/10ps
module arc_props
(
   // Clock and reset
   input wire        clk,
   input wire        rst,
   // Watched ports
   input wire        alarmEvent,
   input wire [7:0]  alarmMain,
   input wire        alarmCauseActive,
   input wire        alarmClearable,
   input wire        ext_alarm_clear_input,
   input wire        commErrEvent,
   input wire        commErrLed,
   input wire        errLed,
   input wire [15:0] active_error_code,
   input wire [3:0]  drive_state_machine,
   input wire        clearDone
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ---------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------
   a_rst_zero: assert property (disable iff (1'b0)
      rst |=> active_error_code == 16'h0000) else $error("code not zero");
   a_clear_state: assert property (
      clearDone |=> drive_state_machine == 4'h1) else $error("no state 1");
   a_clear_from: assert property (
      clearDone |-> drive_state_machine == 4'h8) else $error("not in fault");
   a_react_blocks: assert property (
      drive_state_machine == 4'h4 |-> !clearDone) else $error("react clr");
   a_cause_blocks: assert property (
      clearDone |-> !alarmCauseActive && alarmClearable)
      else $error("cause clr");
   a_upper_byte: assert property (
      active_error_code != 16'h0000 |-> active_error_code[15:8] == 8'hFF)
      else $error("upper byte");
   a_alarm_code: assert property (
      alarmEvent && alarmMain <= 8'h9F && drive_state_machine <= 4'h2
      |=> ##1 active_error_code == {8'hFF, $past(alarmMain, 2)})
      else $error("alarm code");
   a_pin_blocks: assert property (
      ext_alarm_clear_input [*6] |-> !clearDone) else $error("pin clr");
   a_comm_led: assert property (
      commErrEvent |=> errLed == $past(commErrLed)) else $error("led");
   c_clear: cover property (clearDone);
   c_comm: cover property (commErrEvent);
   c_alarm: cover property (alarmEvent);
endmodule

bind arc_alarm_clear arc_props i_props (.*);

// *** bench/arc_fb_master.sv ***
// Fieldbus master model driving the control bytes
`timescale 1ns/10ps
module arc_fb_master
(
   // Clock
   input wire        clk,
   // Control outputs
   output reg [7:0]  alControl,
   output reg [15:0] controlWord
);
   initial
   begin
      alControl = 8'h00;
      controlWord = 16'h0000;
   end
   // Ack bit first, then reset bit from 0 to 1
   task resetCmd(input ack);
   begin
      @(negedge clk);
      alControl[4] = ack;
      controlWord[7] = 1'b0;
      @(negedge clk);
      controlWord[7] = 1'b1;
   end
   endtask
endmodule

// *** bench/tb.sv ***
// Testbench for the alarm report and clear block
`timescale 1ns/10ps
module tb;
   reg        clk = 1'b0;
   reg        rst = 1'b1;
   reg        toolClearReq = 1'b0;
   reg        ext_alarm_clear_input = 1'b0;
   reg        alarmEvent = 1'b0;
   reg [7:0]  alarmMain = 8'h00;
   reg        alarmCauseActive = 1'b0;
   reg        alarmClearable = 1'b0;
   reg        warnCause = 1'b0;
   reg [7:0]  warnNum = 8'h00;
   reg        warnLatchEn = 1'b0;
   reg        faultReactDone = 1'b0;
   reg        enableOperation = 1'b0;
   reg        commErrEvent = 1'b0;
   reg        commRunLed = 1'b0;
   reg        commErrLed = 1'b0;
   reg [3:0]  commBusState = 4'h0;
   reg [15:0] commAlStatus = 16'h0000;
   wire [7:0]  alControl, segDisplay;
   wire [15:0] controlWord, active_error_code, alStatus;
   wire [3:0]  drive_state_machine, busState;
   wire        runLed, errLed, alNotice, clearDone;
   integer     failures = 0;
   integer     n_checks = 0;

   always #5 clk = ~clk;
   arc_fb_master i_mst (.clk(clk), .alControl(alControl),
      .controlWord(controlWord));
   arc_alarm_clear i_dut (.*);
   // ---------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------
   task summarize;
   begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask
   task chk(input [15:0] seen, input [15:0] exp);
   begin
      n_checks = n_checks + 1;
      if (seen !== exp)
      begin
         failures = failures + 1;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   end
   endtask
   task cyc(input integer n);
      repeat (n) @(negedge clk);
   endtask
   task waitClr(input exp);
      reg     seen;
      integer i;
   begin
      seen = 1'b0;
      for (i = 0; i < 8; i = i + 1)
      begin
         @(posedge clk);
         seen = seen | clearDone;
         @(negedge clk);
         toolClearReq = 1'b0;
      end
      chk(seen, exp);
      if (exp && !seen)
         summarize;
   end
   endtask
   task raise(input [7:0] n);
   begin
      @(negedge clk);
      alarmEvent = 1'b1;
      alarmMain = n;
      alarmCauseActive = 1'b1;
      alarmClearable = 1'b1;
      cyc(1);
      alarmEvent = 1'b0;
      chk(drive_state_machine, 4'h4);
      cyc(1);
      chk(active_error_code, {8'hFF, n});
   end
   endtask
   task fault;
   begin
      faultReactDone = 1'b1;
      cyc(2);
      faultReactDone = 1'b0;
      chk(drive_state_machine, 4'h8);
   end
   endtask
   // ---------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------
   task tBus;
   begin
      raise(8'h05);
      alarmCauseActive = 1'b0;
      i_mst.resetCmd(1'b1);
      waitClr(1'b0);
      fault;
      alarmEvent = 1'b1;
      alarmMain = 8'h22;
      cyc(1);
      alarmEvent = 1'b0;
      chk(segDisplay, 8'h05);
      alarmCauseActive = 1'b1;
      i_mst.resetCmd(1'b1);
      waitClr(1'b0);
      i_mst.resetCmd(1'b0);
      waitClr(1'b0);
      alarmCauseActive = 1'b0;
      i_mst.resetCmd(1'b0);
      waitClr(1'b0);
      i_mst.resetCmd(1'b1);
      waitClr(1'b1);
      chk(drive_state_machine, 4'h1);
      chk(active_error_code, 16'h0000);
      chk(alNotice, 1'b0);
      $display("bus clear done");
   end
   endtask
   task tTool;
   begin
      raise(8'h9F);
      fault;
      ext_alarm_clear_input = 1'b1;
      cyc(4);
      alarmCauseActive = 1'b0;
      toolClearReq = 1'b1;
      waitClr(1'b0);
      ext_alarm_clear_input = 1'b0;
      cyc(4);
      toolClearReq = 1'b1;
      waitClr(1'b1);
      chk(drive_state_machine, 4'h1);
      $display("tool clear done");
   end
   endtask
   task tPin;
   begin
      raise(8'h00);
      fault;
      alarmCauseActive = 1'b0;
      ext_alarm_clear_input = 1'b1;
      waitClr(1'b1);
      ext_alarm_clear_input = 1'b0;
      cyc(4);
      chk(drive_state_machine, 4'h1);
      $display("pin clear done");
   end
   endtask
   task tWarn;
   begin
      warnNum = 8'hA3;
      warnCause = 1'b1;
      cyc(2);
      chk(active_error_code, 16'hFFA3);
      raise(8'h31);
      fault;
      alarmCauseActive = 1'b0;
      i_mst.resetCmd(1'b1);
      waitClr(1'b1);
      chk(active_error_code, 16'hFFA3);
      warnLatchEn = 1'b1;
      cyc(1);
      warnCause = 1'b0;
      cyc(2);
      chk(active_error_code, 16'hFFA3);
      i_mst.resetCmd(1'b0);
      cyc(2);
      chk(active_error_code, 16'h0000);
      ext_alarm_clear_input = 1'b1;
      cyc(4);
      warnNum = 8'hC3;
      warnCause = 1'b1;
      cyc(2);
      chk(active_error_code, 16'h0000);
      ext_alarm_clear_input = 1'b0;
      cyc(4);
      chk(active_error_code, 16'hFFC3);
      warnCause = 1'b0;
      ext_alarm_clear_input = 1'b1;
      cyc(5);
      chk(active_error_code, 16'h0000);
      ext_alarm_clear_input = 1'b0;
      warnLatchEn = 1'b0;
      $display("warning done");
   end
   endtask
   task tOper;
   begin
      enableOperation = 1'b1;
      cyc(2);
      chk(drive_state_machine, 4'h2);
      raise(8'h44);
      alarmClearable = 1'b0;
      fault;
      alarmCauseActive = 1'b0;
      i_mst.resetCmd(1'b1);
      waitClr(1'b0);
      chk(segDisplay, 8'h44);
      chk(active_error_code, 16'hFF44);
      chk(alNotice, 1'b1);
      $display("unclearable done");
   end
   endtask
   task tComm;
   begin
      commErrEvent = 1'b1;
      commErrLed = 1'b1;
      commRunLed = 1'b1;
      commBusState = 4'h2;
      commAlStatus = 16'h001B;
      cyc(1);
      commErrLed = 1'b0;
      commRunLed = 1'b0;
      commBusState = 4'h8;
      commAlStatus = 16'h0022;
      cyc(1);
      commErrEvent = 1'b0;
      cyc(1);
      chk({errLed, runLed, busState}, 6'h08);
      chk(alStatus, 16'h0022);
      $display("comm error done");
   end
   endtask

   initial
   begin
      cyc(8);
      rst = 1'b0;
      chk(active_error_code, 16'h0000);
      chk(drive_state_machine, 4'h1);
      tBus;
      tTool;
      tPin;
      tWarn;
      tOper;
      tComm;
      summarize;
   end
endmodule
